// *** logic/sart_regs.svh ***
// constants for the sensor address, reset and timing block
`ifndef SART_REGS_SVH
`define SART_REGS_SVH
`define SART_CMD_SOFT_RESET   8'hFC
`define SART_CMD_ADDR_WRITE   8'hFD
`define SART_CMD_ONE_SHOT     8'h0F
`define SART_CMD_RATE_WRITE   8'h0A
`define SART_CMD_CONFIG_WRITE 8'h09
`define SART_ALERT_RESP_ADDR  7'h0C
`define SART_CFG_STOP_BIT     6
`define SART_CFG_LOCK_BIT     4
`define SART_RATE_RESET       3'h2
`define SART_CFG_RESET        8'h0C
`define SART_CLK_HZ           50000000
`define SART_TICK_US          100
`define SART_TICK_CYC         ((`SART_CLK_HZ / 1000000) * `SART_TICK_US)
`define SART_CONV_MS          125
`define SART_CONV_TICKS       ((`SART_CONV_MS * 1000) / `SART_TICK_US)
`define SART_STRAP_WAIT_US    20
`define SART_STRAP_WAIT_CYC   ((`SART_CLK_HZ / 1000000) * `SART_STRAP_WAIT_US)
`define SART_PERIOD_MS_SLOW   16000
`endif

// *** logic/sart_pkg.sv ***
// types for the sensor address, reset and timing block
package sart_pkg;
  typedef enum logic [1:0] {
    STRAP_LOW   = 2'b00,
    STRAP_FLOAT = 2'b01,
    STRAP_HIGH  = 2'b10
  } sart_strap_t;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b000,
    BUS_ADDR = 3'b001,
    BUS_ACK  = 3'b010,
    BUS_DATA = 3'b011,
    BUS_DACK = 3'b100,
    BUS_SKIP = 3'b101
  } sart_bus_st_t;

  typedef struct packed {
    logic       drive;
    logic       pull_up;
  } sart_probe_t;
endpackage

// *** logic/sart_strap_dec.sv ***
// three-level strap sampler and address decoder
`timescale 1ns/1ps
`include "sart_regs.svh"
module sart_strap_dec
(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  // control
  input  wire logic                 sample_go,
  output      logic                 sample_done,
  output      logic [6:0]           strap_addr,
  // strap pins: pad level and weak probe drive
  input  wire logic                 addr_strap_first,
  input  wire logic                 addr_strap_second,
  output      sart_pkg::sart_probe_t probe
);
  typedef struct packed {
    logic [1:0]  phase;
    logic [15:0] wait_cnt;
    logic [1:0]  s1a;
    logic [1:0]  s2a;
    logic [1:0]  lvl_up;
    logic [6:0]  addr;
    logic        done;
  } sart_sd_t;

  sart_sd_t st_r;
  sart_sd_t st_nxt;

  // phase 1 probes pulled up, phase 2 pulled down; both seen after settling
  function automatic sart_pkg::sart_strap_t classify(input logic up, input logic dn);
    if (up && dn)
      classify = sart_pkg::STRAP_HIGH;
    else if (!up && !dn)
      classify = sart_pkg::STRAP_LOW;
    else
      classify = sart_pkg::STRAP_FLOAT;
  endfunction

  function automatic logic [6:0] decode(input sart_pkg::sart_strap_t a,
                                        input sart_pkg::sart_strap_t b);
    logic [3:0] hi;
    logic [2:0] lo;
    logic [2:0] step;
    hi   = 4'h3;
    lo   = 3'h0;
    step = 3'h0;
    if (a == sart_pkg::STRAP_FLOAT)
    begin
      hi = 4'h5;
      lo = 3'h1;
    end
    else if (a == sart_pkg::STRAP_HIGH)
    begin
      hi = 4'h9;
      lo = 3'h4;
    end
    if (b == sart_pkg::STRAP_FLOAT)
      step = 3'h1;
    else if (b == sart_pkg::STRAP_HIGH)
      step = 3'h2;
    decode = {hi, 3'(lo + step)};
  endfunction

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.s1a = {st_r.s1a[0], addr_strap_first};
    st_nxt.s2a = {st_r.s2a[0], addr_strap_second};
    // done is a pulse, so a stale result never relatches after a soft reset
    st_nxt.done = 1'b0;
    case (st_r.phase)
      2'h0:
      begin
        if (sample_go)
        begin
          st_nxt.phase    = 2'h1;
          st_nxt.wait_cnt = 16'(`SART_STRAP_WAIT_CYC);
          st_nxt.done     = 1'b0;
        end
      end
      2'h1:
      begin
        if (st_r.wait_cnt == 16'h0000)
        begin
          st_nxt.lvl_up   = {st_r.s1a[1], st_r.s2a[1]};
          st_nxt.phase    = 2'h2;
          st_nxt.wait_cnt = 16'(`SART_STRAP_WAIT_CYC);
        end
        else
          st_nxt.wait_cnt = st_r.wait_cnt - 16'h0001;
      end
      default:
      begin
        if (st_r.wait_cnt == 16'h0000)
        begin
          st_nxt.addr  = decode(classify(st_r.lvl_up[1], st_r.s1a[1]),
                                classify(st_r.lvl_up[0], st_r.s2a[1]));
          st_nxt.phase = 2'h0;
          st_nxt.done  = 1'b1;
        end
        else
          st_nxt.wait_cnt = st_r.wait_cnt - 16'h0001;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign sample_done   = st_r.done;
  assign strap_addr    = st_r.addr;
  // probing only while sampling keeps bias current off afterwards
  assign probe.drive   = (st_r.phase != 2'h0);
  assign probe.pull_up = (st_r.phase == 2'h1);
endmodule

// *** logic/sart_top.sv ***
// serial slave front end with address straps, resets and conversion timing
`timescale 1ns/1ps
`include "sart_regs.svh"
module sart_top
#(
  parameter int TICK_CYC = `SART_TICK_CYC
)
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  // supply monitors
  input  wire logic                  por_low,
  input  wire logic                  uvlo,
  // serial bus, open drain data
  input  wire logic                  smb_clk,
  input  wire logic                  smb_data_in,
  output      logic                  smb_data_out,
  output      logic                  smb_data_oe,
  // straps and standby
  input  wire logic                  addr_strap_first,
  input  wire logic                  addr_strap_second,
  output      sart_pkg::sart_probe_t strap_probe,
  input  wire logic                  standby_pin,
  // converter handshake and status
  output      logic                  conv_start,
  output      logic                  conv_busy,
  output      logic                  temp_update,
  output      logic [6:0]            slave_addr,
  output      logic [2:0]            conv_rate,
  output      logic [7:0]            config_reg,
  output      logic                  addr_valid
);
  typedef struct packed {
    logic [1:0]              c_sy;
    logic [1:0]              d_sy;
    logic [1:0]              stb_sy;
    logic                    c_d;
    logic                    d_d;
    sart_pkg::sart_bus_st_t  bst;
    logic [3:0]              bit_cnt;
    logic [7:0]              shreg;
    logic                    byte_no;
    logic [7:0]              cmd;
    logic                    sda_low;
    logic                    soft_pend;
    logic                    addr_wr;
    logic [6:0]              addr;
    logic                    valid;
    logic [2:0]              rate;
    logic [7:0]              cfg;
    logic                    lock;
    logic                    one_shot;
    logic [15:0]             tick_cyc;
    logic [17:0]             ticks;
    logic                    busy;
    logic [17:0]             period_left;
    logic                    start_p;
    logic                    upd_p;
    logic                    go;
    logic                    halt_d;
  } sart_st_t;

  sart_st_t st_r;
  sart_st_t st_nxt;
  logic     samp_done;
  logic     tick;
  logic     c_rise;
  logic     c_fall;
  logic     start_c;
  logic     stop_c;
  logic [6:0] strap_val;

  sart_strap_dec u_strap
  (
    .clk               (clk),
    .sys_rst           (sys_rst),
    .sample_go         (st_r.go),
    .sample_done       (samp_done),
    .strap_addr        (strap_val),
    .addr_strap_first  (addr_strap_first),
    .addr_strap_second (addr_strap_second),
    .probe             (strap_probe)
  );
  // period in 100 us ticks; every rate adds conversion time on top
  function automatic logic [17:0] period_ticks(input logic [2:0] r);
    period_ticks = 18'(((`SART_PERIOD_MS_SLOW * 10) >> r));
  endfunction

  assign c_rise  = st_r.c_sy[1] & ~st_r.c_d;
  assign c_fall  = ~st_r.c_sy[1] & st_r.c_d;
  assign start_c = st_r.c_sy[1] & st_r.d_d & ~st_r.d_sy[1];
  assign stop_c  = st_r.c_sy[1] & ~st_r.d_d & st_r.d_sy[1];
  assign tick    = (st_r.tick_cyc == 16'(TICK_CYC - 1));

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.c_sy    = {st_r.c_sy[0], smb_clk};
    st_nxt.d_sy    = {st_r.d_sy[0], smb_data_in};
    st_nxt.stb_sy  = {st_r.stb_sy[0], standby_pin};
    st_nxt.c_d     = st_r.c_sy[1];
    st_nxt.d_d     = st_r.d_sy[1];
    st_nxt.start_p = 1'b0;
    st_nxt.upd_p   = 1'b0;
    st_nxt.go      = 1'b0;
    st_nxt.halt_d  = st_r.cfg[`SART_CFG_STOP_BIT] | st_r.stb_sy[1];
    st_nxt.tick_cyc = tick ? 16'h0000 : st_r.tick_cyc + 16'h0001;

    if (samp_done && !st_r.valid)
    begin
      st_nxt.addr  = strap_val;
      st_nxt.valid = 1'b1;
    end

    // serial slave
    if (start_c)
    begin
      st_nxt.bst     = sart_pkg::BUS_ADDR;
      st_nxt.bit_cnt = 4'h0;
      st_nxt.byte_no = 1'b0;
      st_nxt.sda_low = 1'b0;
    end
    else if (stop_c)
    begin
      st_nxt.bst     = sart_pkg::BUS_IDLE;
      st_nxt.sda_low = 1'b0;
      if (st_r.soft_pend)
      begin
        st_nxt.soft_pend = 1'b0;
        st_nxt.valid     = 1'b0;
        st_nxt.rate      = `SART_RATE_RESET;
        st_nxt.cfg       = `SART_CFG_RESET;
        st_nxt.cfg[`SART_CFG_LOCK_BIT] = st_r.lock;
        st_nxt.go        = 1'b1;
      end
    end
    else
    begin
      case (st_r.bst)
        sart_pkg::BUS_ADDR, sart_pkg::BUS_DATA:
        begin
          if (c_rise)
          begin
            st_nxt.shreg   = {st_r.shreg[6:0], st_r.d_sy[1]};
            st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
          end
          if (c_fall && st_r.bit_cnt == 4'h8)
          begin
            st_nxt.bit_cnt = 4'h0;
            if (st_r.bst == sart_pkg::BUS_ADDR)
            begin
              if (st_r.valid && (st_r.shreg[7:1] == st_r.addr ||
                  st_r.shreg[7:1] == `SART_ALERT_RESP_ADDR))
              begin
                st_nxt.bst     = sart_pkg::BUS_ACK;
                st_nxt.sda_low = 1'b1;
              end
              else
                st_nxt.bst = sart_pkg::BUS_SKIP;
            end
            else
            begin
              st_nxt.bst     = sart_pkg::BUS_DACK;
              st_nxt.sda_low = 1'b1;
              if (!st_r.byte_no)
              begin
                st_nxt.cmd     = st_r.shreg;
                st_nxt.byte_no = 1'b1;
                if (st_r.shreg == `SART_CMD_SOFT_RESET)
                  st_nxt.soft_pend = 1'b1;
                if (st_r.shreg == `SART_CMD_ONE_SHOT && !st_r.busy)
                  st_nxt.one_shot = 1'b1;
              end
              else if (st_r.cmd == `SART_CMD_ADDR_WRITE)
                st_nxt.addr = st_r.shreg[6:0];
              else if (st_r.cmd == `SART_CMD_RATE_WRITE && !st_r.lock)
              begin
                st_nxt.rate        = st_r.shreg[2:0];
                st_nxt.period_left = period_ticks(st_r.shreg[2:0]);
              end
              else if (st_r.cmd == `SART_CMD_CONFIG_WRITE)
              begin
                if (st_r.lock)
                  st_nxt.cfg = {st_r.shreg[7], st_r.cfg[6:2], st_r.shreg[1:0]};
                else
                begin
                  st_nxt.cfg = st_r.shreg;
                  if (st_r.shreg[`SART_CFG_LOCK_BIT])
                    st_nxt.lock = 1'b1;
                end
              end
            end
          end
        end
        sart_pkg::BUS_ACK, sart_pkg::BUS_DACK:
        begin
          if (c_fall)
          begin
            st_nxt.sda_low = 1'b0;
            st_nxt.bst     = sart_pkg::BUS_DATA;
          end
        end
        default:
        begin
        end
      endcase
    end

    // conversion sequencing in timebase ticks
    if (tick)
    begin
      if (st_r.busy)
      begin
        if (st_r.ticks == 18'h00000)
        begin
          st_nxt.busy  = 1'b0;
          st_nxt.upd_p = 1'b1;
        end
        else
          st_nxt.ticks = st_r.ticks - 18'h00001;
      end
      else if (st_r.period_left != 18'h00000)
        st_nxt.period_left = st_r.period_left - 18'h00001;
    end
    if (st_r.cfg[`SART_CFG_STOP_BIT] || st_r.stb_sy[1])
    begin
      // cut only on entry, so a standby one-shot runs to its update
      if (!st_r.halt_d)
        st_nxt.busy      = 1'b0;
      st_nxt.period_left = 18'h00000;
    end
    else if (!uvlo && !st_r.busy && (st_r.one_shot || st_r.period_left == 18'h00000))
    begin
      // start at once, 125 ms conversion
      st_nxt.busy        = 1'b1;
      st_nxt.start_p     = 1'b1;
      st_nxt.one_shot    = 1'b0;
      st_nxt.ticks       = 18'(`SART_CONV_TICKS - 1);
      st_nxt.period_left = period_ticks(st_r.rate);
    end
    // one-shot in standby still converts
    if (st_r.one_shot && (st_r.cfg[`SART_CFG_STOP_BIT] || st_r.stb_sy[1]) && !uvlo)
    begin
      st_nxt.busy     = 1'b1;
      st_nxt.start_p  = 1'b1;
      st_nxt.one_shot = 1'b0;
      st_nxt.ticks    = 18'(`SART_CONV_TICKS - 1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst || por_low)
    begin
      st_r       <= '0;
      st_r.rate  <= `SART_RATE_RESET;
      st_r.cfg   <= `SART_CFG_RESET;
      st_r.c_sy  <= 2'b11;
      st_r.d_sy  <= 2'b11;
      st_r.c_d   <= 1'b1;
      st_r.d_d   <= 1'b1;
      st_r.go    <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  always_comb
  begin
    smb_data_out = 1'b0;
    smb_data_oe  = st_r.sda_low;
  end

  assign conv_start  = st_r.start_p;
  assign conv_busy   = st_r.busy;
  assign temp_update = st_r.upd_p;
  assign slave_addr  = st_r.addr;
  assign conv_rate   = st_r.rate;
  assign config_reg  = st_r.cfg;
  assign addr_valid  = st_r.valid;
endmodule

// *** testbench/sart_top_chk.sv ***
// assertion checker on the top ports of the sensor block
`timescale 1ns/1ps
module sart_top_chk
#(
  parameter int TICK_CYC = 5000
)
(
  // clock and reset
  input wire logic                  clk,
  input wire logic                  sys_rst,
  // supply monitors
  input wire logic                  por_low,
  input wire logic                  uvlo,
  // outputs watched
  input wire logic                  smb_data_oe,
  input wire sart_pkg::sart_probe_t strap_probe,
  input wire logic                  conv_start,
  input wire logic                  conv_busy,
  input wire logic [2:0]            conv_rate,
  input wire logic [7:0]            config_reg,
  input wire logic                  addr_valid
);
  // ---------------------------------------
  // busy length counter
  // ---------------------------------------
  logic [31:0] busy_cnt_r;
  logic [31:0] busy_cnt_nxt;
  always_comb busy_cnt_nxt = conv_busy ? busy_cnt_r + 32'h1 : 32'h0;
  always_ff @(posedge clk) busy_cnt_r <= sys_rst ? 32'h0 : busy_cnt_nxt;
  // ---------------------------------------
  // unlatched length counter
  // ---------------------------------------
  // a plain delay range would be too long to unroll
  logic [15:0] low_cnt_r;
  always_ff @(posedge clk) low_cnt_r <= (sys_rst || addr_valid) ? 16'h0000 : low_cnt_r + 16'h0001;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // lockout held long enough to cover the registered start pulse
  sequence s_lockout;
    uvlo [*4];
  endsequence
  sequence s_por;
    por_low [*4];
  endsequence
  AST_NO_ACK_UNLATCHED:
    assert property (!addr_valid |-> !smb_data_oe) else $error("ack before latch");
  AST_PROBE_OFF:
    assert property (addr_valid |-> !strap_probe.drive) else $error("probe on");
  AST_RESAMPLE_BOUND:
    assert property (!addr_valid |-> low_cnt_r < 16'h1388) else $error("slow latch");
  AST_LOCKOUT:
    assert property (s_lockout |-> !conv_start) else $error("start in lockout");
  AST_START_BUSY:
    assert property (conv_start |=> conv_busy) else $error("start without busy");
  AST_BUSY_NO_START:
    assert property (conv_busy && $past(conv_busy) |-> !conv_start) else $error("restart");
  AST_CONV_BOUND:
    assert property (conv_busy |-> busy_cnt_r < 32'(1560 * TICK_CYC)) else $error("long");
  AST_STOP_HALTS:
    assert property ($rose(config_reg[6]) |-> ##[0:3] !conv_busy) else $error("no stop");
  AST_POR_DEFAULTS:
    assert property (s_por |-> ##[0:3] (config_reg == 8'h0C && conv_rate == 3'h2))
      else $error("por defaults");
  AST_RATE_RESET:
    assert property ($fell(sys_rst) |-> conv_rate == 3'h2) else $error("rate reset");
endmodule
bind sart_top sart_top_chk #(.TICK_CYC(TICK_CYC)) i_sart_top_chk (
  .clk(clk), .sys_rst(sys_rst), .por_low(por_low), .uvlo(uvlo),
  .smb_data_oe(smb_data_oe), .strap_probe(strap_probe), .conv_start(conv_start),
  .conv_busy(conv_busy), .conv_rate(conv_rate), .config_reg(config_reg),
  .addr_valid(addr_valid));

// *** testbench/sart_host_model.sv ***
// bus host model: start, address, bytes, stop
`timescale 1ns/1ps
module sart_host_model
(
  // clock
  input  wire logic clk,
  // bus lines
  output      logic smb_clk,
  output      logic smb_data_in,
  input  wire logic smb_data_oe
);
  // ---------------------------------------
  // open drain data with pull-up
  // ---------------------------------------
  logic host_low = 1'b0;
  initial smb_clk = 1'b1;
  assign smb_data_in = ~(host_low | smb_data_oe);
  task automatic q(input int n);
    repeat (n) @(posedge clk);
  endtask
  // read at end of high phase, so a slow ack has settled
  task automatic bitx(input logic v, output logic r);
    smb_clk <= 1'b0;
    q(2);
    host_low <= ~v;
    q(2);
    smb_clk <= 1'b1;
    q(4);
    r = smb_data_in;
  endtask
  task automatic byte_x(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(b[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask
  // clock stands high between frames
  task automatic send(input logic [6:0] a, input int n, input logic [7:0] c,
                      input logic [7:0] d, output logic ok);
    logic k;
    host_low <= 1'b1;
    q(4);
    byte_x({a, 1'b0}, ok);
    for (int j = 0; j < n; j++)
    begin
      byte_x(j == 0 ? c : d, k);
      ok = ok & k;
    end
    smb_clk <= 1'b0;
    q(2);
    host_low <= 1'b1;
    q(2);
    smb_clk <= 1'b1;
    q(2);
    host_low <= 1'b0;
    q(8);
  endtask
endmodule

// *** testbench/test_sart_top.sv ***
// self-checking bench for the sensor address, reset and timing block
`timescale 1ns/1ps
module test_sart_top;
  // ---------------------------------------
  // stimulus and wires
  // ---------------------------------------
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic por_low = 1'b0;
  logic uvlo = 1'b0;
  logic standby_pin = 1'b0;
  logic smb_clk, smb_data_in, smb_data_oe, pad_first, pad_second;
  logic conv_start, conv_busy, temp_update, addr_valid, ack, sdo;
  logic [6:0] slave_addr, a;
  logic [2:0] conv_rate;
  logic [7:0] config_reg, d;
  sart_pkg::sart_probe_t prb;
  int sf = 1, ss = 1, fail_count = 0, n_tests = 0, cyc = 0, n_starts = 0, k, s0;
  always #10 clk = ~clk;
  // floating strap follows the probe, else wanders
  assign pad_first = sf == 2 || (sf == 1 && (prb.drive ? prb.pull_up : ~clk));
  assign pad_second = ss == 2 || (ss == 1 && (prb.drive ? prb.pull_up : ~clk));
  sart_top #(.TICK_CYC(10)) i_sart_top (
    .clk(clk), .sys_rst(sys_rst), .por_low(por_low), .uvlo(uvlo), .smb_clk(smb_clk),
    .smb_data_in(smb_data_in), .smb_data_out(sdo), .smb_data_oe(smb_data_oe),
    .addr_strap_first(pad_first), .addr_strap_second(pad_second), .strap_probe(prb),
    .standby_pin(standby_pin), .conv_start(conv_start), .conv_busy(conv_busy),
    .temp_update(temp_update), .slave_addr(slave_addr), .conv_rate(conv_rate),
    .config_reg(config_reg), .addr_valid(addr_valid));
  sart_host_model i_host (.clk(clk), .smb_clk(smb_clk), .smb_data_in(smb_data_in),
    .smb_data_oe(smb_data_oe));
  // ---------------------------------------
  // helpers and reference model
  // ---------------------------------------
  task automatic q(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    n_tests++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic report_and_stop();
    if (fail_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic wait_valid();
    for (k = 0; k < 6000 && addr_valid !== 1'b1; k++) q(1);
  endtask
  task automatic wait_upd();
    for (k = 0; k < 16000 && temp_update !== 1'b1; k++) q(1);
  endtask
  function automatic logic [7:0] dec(input int f, input int s);
    return 8'((f == 0 ? 24 : f == 1 ? 41 : 76) + s);
  endfunction
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    n_starts <= n_starts + int'(conv_start === 1'b1);
    if (cyc == 95000)
    begin
      fail_count++;
      report_and_stop();
    end
  end
  initial
  begin
    k = $urandom(6448);
    q(16);
    sys_rst <= 1'b0;
    wait_valid();
    chk(config_reg, 8'h0C, "config reset");
    chk(8'(conv_rate), 8'h02, "rate reset");
    for (int i = 0; i < 9; i++)
    begin
      sf <= i / 3;
      ss <= i % 3;
      q(2);
      i_host.send(slave_addr, 1, 8'hFC, 8'h00, ack);
      wait_valid();
      chk(8'(k < 5000), 8'h01, "resample slow");
      chk(8'(slave_addr), dec(i / 3, i % 3), "strap addr");
    end
    sf <= 0;
    q(300);
    chk(8'(slave_addr), dec(2, 2), "latched addr");
    i_host.send(slave_addr, 1, 8'hFC, 8'h00, ack);
    i_host.send(7'h4E, 0, 8'h00, 8'h00, ack);
    chk(8'(ack), 8'h00, "ack while sampling");
    wait_valid();
    chk(8'(slave_addr), dec(0, 2), "resampled addr");
    d = 8'($urandom_range(16, 119));
    a = d[6:0];
    i_host.send(slave_addr, 2, 8'hFD, d, ack);
    chk(8'(slave_addr), d, "written addr");
    i_host.send(a, 0, 8'h00, 8'h00, ack);
    chk(8'(ack), 8'h01, "new addr ack");
    i_host.send(7'h0C, 0, 8'h00, 8'h00, ack);
    chk(8'(ack), 8'h01, "alert addr ack");
    chk(8'(sdo), 8'h00, "data out level");
    i_host.send(a + 7'h1, 0, 8'h00, 8'h00, ack);
    chk(8'(ack), 8'h00, "foreign addr ack");
    d = 8'($urandom);
    i_host.send(a, 2, 8'h0A, d, ack);
    chk(8'(conv_rate), 8'(d[2:0]), "rate write");
    // slowest rate keeps the timer out of the one-shot checks
    i_host.send(a, 2, 8'h0A, 8'hF8, ack);
    chk(8'(conv_rate), 8'h00, "rate low bits");
    for (k = 0; k < 20000 && conv_busy !== 1'b0; k++) q(1);
    s0 = n_starts;
    i_host.send(a, 1, 8'h0F, 8'h00, ack);
    i_host.send(a, 1, 8'h0F, 8'h00, ack);
    wait_upd();
    chk(8'(k < 15600), 8'h01, "one-shot update");
    chk(8'(n_starts - s0), 8'h01, "busy one-shot");
    i_host.send(a, 1, 8'h0F, 8'h00, ack);
    i_host.send(a, 2, 8'h09, 8'h4C, ack);
    q(4);
    chk(8'(conv_busy), 8'h00, "stop halts");
    uvlo <= 1'b1;
    s0 = n_starts;
    i_host.send(a, 1, 8'h0F, 8'h00, ack);
    q(300);
    chk(8'(n_starts - s0), 8'h00, "lockout start");
    uvlo <= 1'b0;
    q(4);
    i_host.send(a, 1, 8'h0F, 8'h00, ack);
    wait_upd();
    chk(8'(k < 15600), 8'h01, "standby update");
    i_host.send(a, 2, 8'h09, 8'h1C, ack);
    i_host.send(a, 1, 8'hFC, 8'h00, ack);
    wait_valid();
    chk(8'(config_reg[4]), 8'h01, "lock kept");
    chk(8'(conv_rate), 8'h02, "soft reset rate");
    por_low <= 1'b1;
    q(4);
    por_low <= 1'b0;
    wait_valid();
    chk(config_reg, 8'h0C, "por clears");
    report_and_stop();
  end
endmodule
